/* File: rtl/pbt_pkg.sv */
// Constants, field layouts and carrier types of the pattern bit error tester.
// Assumes a single 200 MHz system clock; all pins are synchronised by the top module.
package pbt_pkg;

    // ======================================================================
    // Timing
    // ======================================================================
    localparam longint CLK_HZ = 200_000_000;
    localparam longint CLK_LOSS_MS = 30;
    localparam longint BIT_ERROR_S = 1;
    localparam int CLK_LOSS_CYCLES = int'(CLK_HZ / 1000 * CLK_LOSS_MS);
    localparam int BIT_ERROR_CYCLES = int'(CLK_HZ * BIT_ERROR_S);
    localparam int TIMER_W = 28;

    // ======================================================================
    // Dividers
    // ======================================================================
    localparam logic [3:0] DIV9_LAST = 4'h8;
    localparam logic [3:0] SEQ13_LAST = 4'hc;
    localparam logic [3:0] DIV13_LAST = 4'hc;
    localparam logic [3:0] DIV16_LAST = 4'hf;
    localparam logic [3:0] SEQ13_NO_EXTRA = 4'h0;

    // ======================================================================
    // Pattern and error density
    // ======================================================================
    localparam int LFSR_W = 11;
    localparam int LFSR_TAP_HI = 10;
    localparam int LFSR_TAP_LO = 8;
    localparam logic [15:0] RING_START = 16'h0001;
    localparam int MIDBIT_STEP = 7;
    localparam logic [3:0] SYNC_WINDOW_LAST = 4'hf;
    localparam logic [13:0] ERR_WINDOW_LAST = 14'h3fff;
    localparam logic [7:0] ERR_LIMIT = 8'ha4;

    // ======================================================================
    // Register map
    // ======================================================================
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] ERRCNT_OFFSET = 8'h08;
    localparam int CTRL_FN_LSB = 0;
    localparam int CTRL_INJECT_BIT = 2;
    localparam int CTRL_VOICE_EN_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    typedef enum logic [1:0] {
        FN_RATE_50K,
        FN_RATE_20K,
        FN_EXTERNAL,
        FN_SELF_TEST
    } pbt_function_t;

    typedef struct packed {
        logic self_test_fail;
        logic error_density_alarm;
        logic bit_error;
        logic receive_clock_missing;
        logic in_sync;
    } pbt_lamps_t;

endpackage

/* File: rtl/pbt_tester.sv */
// Pattern bit error tester: clock dividers, pattern generator, detector,
// error density integrator, indicators and an AHB-Lite register slave.
// Assumes all pin inputs are asynchronous to hclk and far slower than 200 MHz.
`timescale 1ns/1ps

module pbt_tester #(
    parameter int CLK_LOSS_CYC = pbt_pkg::CLK_LOSS_CYCLES,
    parameter int BIT_ERROR_CYC = pbt_pkg::BIT_ERROR_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic master_clock_in,
    input wire logic external_clock_in,
    input wire logic receive_pattern_in,
    input wire logic receive_clock_in,
    input wire logic voice_path_check_fail_in,
    output logic transmit_clock_out,
    output logic transmit_pattern_out,
    output logic frame_marker_out,
    output pbt_pkg::pbt_lamps_t lamps_out
);
    import pbt_pkg::*;

    function automatic logic lfsr_feedback(input logic [LFSR_W-1:0] r);
        lfsr_feedback = r[LFSR_TAP_HI] ^ r[LFSR_TAP_LO];
    endfunction

    function automatic logic rise(input logic [2:0] s);
        rise = s[1] & ~s[2];
    endfunction

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    // Bit 0 is the metastable stage; only bit 1 and later are read by logic.
    logic [2:0] mclk_sync_reg;
    logic [2:0] ext_sync_reg;
    logic [2:0] rclk_sync_reg;
    logic [1:0] rdata_sync_reg;
    logic [1:0] vfail_sync_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mclk_sync_reg <= 3'h0;
            ext_sync_reg <= 3'h0;
            rclk_sync_reg <= 3'h0;
            rdata_sync_reg <= 2'h0;
            vfail_sync_reg <= 2'h0;
        end else begin
            mclk_sync_reg <= {mclk_sync_reg[1:0], master_clock_in};
            ext_sync_reg <= {ext_sync_reg[1:0], external_clock_in};
            rclk_sync_reg <= {rclk_sync_reg[1:0], receive_clock_in};
            rdata_sync_reg <= {rdata_sync_reg[0], receive_pattern_in};
            vfail_sync_reg <= {vfail_sync_reg[0], voice_path_check_fail_in};
        end
    end

    logic master_tick;
    assign master_tick = rise(mclk_sync_reg);

    // ======================================================================
    // Register file
    // ======================================================================
    logic [3:0] ctrl_reg;
    pbt_function_t func;
    logic inject_req;
    logic voice_en;
    assign func = pbt_function_t'(ctrl_reg[CTRL_FN_LSB +: 2]);
    assign inject_req = ctrl_reg[CTRL_INJECT_BIT];
    assign voice_en = ctrl_reg[CTRL_VOICE_EN_BIT];

    logic self_test;
    logic slow_rate;
    assign self_test = (func == FN_SELF_TEST);
    assign slow_rate = (func == FN_RATE_20K) || self_test;

    // ======================================================================
    // Master clock dividers
    // ======================================================================
    logic [3:0] div9a_reg;
    logic [3:0] div9b_reg;
    logic [3:0] seq13_reg;
    logic extra_reg;
    logic tick50_reg;
    logic [3:0] div13_reg;
    logic tick320_reg;
    logic [3:0] div16_reg;
    logic tick20_reg;

    // The 50 kHz period alternates between 81 and 82 master cycles; twelve of
    // every thirteen periods take the extra count, giving 49.998 kHz on average.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div9a_reg <= 4'h0;
            div9b_reg <= 4'h0;
            seq13_reg <= 4'h0;
            extra_reg <= 1'b0;
            tick50_reg <= 1'b0;
        end else begin
            tick50_reg <= 1'b0;
            if (master_tick) begin
                if (extra_reg) begin
                    extra_reg <= 1'b0;
                    tick50_reg <= 1'b1;
                end else if (div9a_reg == DIV9_LAST) begin
                    div9a_reg <= 4'h0;
                    if (div9b_reg == DIV9_LAST) begin
                        div9b_reg <= 4'h0;
                        seq13_reg <= (seq13_reg == SEQ13_LAST) ? 4'h0 : seq13_reg + 4'h1;
                        if (seq13_reg == SEQ13_NO_EXTRA) begin
                            tick50_reg <= 1'b1;
                        end else begin
                            extra_reg <= 1'b1;
                        end
                    end else begin
                        div9b_reg <= div9b_reg + 4'h1;
                    end
                end else begin
                    div9a_reg <= div9a_reg + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div13_reg <= 4'h0;
            tick320_reg <= 1'b0;
            div16_reg <= 4'h0;
            tick20_reg <= 1'b0;
        end else begin
            tick320_reg <= 1'b0;
            tick20_reg <= 1'b0;
            if (master_tick) begin
                div13_reg <= (div13_reg == DIV13_LAST) ? 4'h0 : div13_reg + 4'h1;
                tick320_reg <= (div13_reg == DIV13_LAST);
            end
            if (tick320_reg) begin
                div16_reg <= div16_reg + 4'h1;
                tick20_reg <= (div16_reg == DIV16_LAST);
            end
        end
    end

    // ======================================================================
    // Transmit clock selection and pattern generator
    // ======================================================================
    logic tx_advance;
    always_comb begin
        case (func)
            FN_RATE_50K: tx_advance = tick50_reg;
            FN_RATE_20K: tx_advance = tick20_reg;
            FN_EXTERNAL: tx_advance = rise(ext_sync_reg);
            FN_SELF_TEST: tx_advance = tick20_reg;
            default: tx_advance = 1'b0;
        endcase
    end

    logic [LFSR_W-1:0] gen_reg;
    logic gen_all_ones;
    assign gen_all_ones = &gen_reg;

    // Reset to a nonzero seed: the all-zero state would lock the register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_reg <= {{(LFSR_W-1){1'b0}}, 1'b1};
        end else if (tx_advance) begin
            gen_reg <= {gen_reg[LFSR_W-2:0], gen_all_ones ? 1'b0 : lfsr_feedback(gen_reg)};
        end
    end

    // The transmit clock is driven high on each step and low at the next master tick that brings no step.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transmit_clock_out <= 1'b0;
            transmit_pattern_out <= 1'b0;
            frame_marker_out <= 1'b0;
        end else begin
            if (tx_advance) begin
                transmit_clock_out <= 1'b1;
            end else if (master_tick) begin
                transmit_clock_out <= 1'b0;
            end
            transmit_pattern_out <= gen_reg[LFSR_W-1] ^ (inject_req & gen_all_ones);
            frame_marker_out <= gen_all_ones;
        end
    end

    // ======================================================================
    // Receive path and mid-bit clock recovery
    // ======================================================================
    logic rx_src;
    assign rx_src = self_test ? transmit_pattern_out : rdata_sync_reg[1];

    logic [1:0] samp_reg;
    logic [1:0] trans_reg;
    logic [15:0] ring_reg;
    logic midbit_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_reg <= 2'h0;
            trans_reg <= 2'h0;
            ring_reg <= 16'h0;
            midbit_reg <= 1'b0;
        end else begin
            midbit_reg <= 1'b0;
            if (tick320_reg) begin
                samp_reg <= {samp_reg[0], rx_src};
                trans_reg <= {trans_reg[0], samp_reg[0] ^ samp_reg[1]};
                ring_reg <= trans_reg[0] ? RING_START : {ring_reg[14:0], ring_reg[15]};
                midbit_reg <= ~trans_reg[0] & ring_reg[MIDBIT_STEP-1];
            end
        end
    end

    logic rx_strobe;
    logic rx_bit;
    assign rx_strobe = slow_rate ? midbit_reg : rise(rclk_sync_reg);
    assign rx_bit = slow_rate ? samp_reg[1] : rx_src;

    // ======================================================================
    // Word detector
    // ======================================================================
    logic [LFSR_W-1:0] det_reg;
    logic in_sync_reg;
    logic predicted;
    logic err_pulse;
    assign predicted = lfsr_feedback(det_reg);
    assign err_pulse = rx_strobe & (rx_bit ^ predicted);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            det_reg <= {LFSR_W{1'b0}};
        end else if (rx_strobe) begin
            det_reg <= {det_reg[LFSR_W-2:0], in_sync_reg ? predicted : rx_bit};
        end
    end

    // ======================================================================
    // Indicator timers
    // ======================================================================
    logic [TIMER_W-1:0] loss_timer_reg;
    logic [TIMER_W-1:0] err_timer_reg;
    logic clk_missing;
    logic quiet_expire;
    assign clk_missing = (loss_timer_reg == '0);
    assign quiet_expire = (err_timer_reg == TIMER_W'(1)) & ~err_pulse;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loss_timer_reg <= '0;
        end else if (rx_strobe) begin
            loss_timer_reg <= TIMER_W'(CLK_LOSS_CYC);
        end else if (!clk_missing) begin
            loss_timer_reg <= loss_timer_reg - TIMER_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_timer_reg <= '0;
        end else if (err_pulse) begin
            err_timer_reg <= TIMER_W'(BIT_ERROR_CYC);
        end else if (err_timer_reg != '0) begin
            err_timer_reg <= err_timer_reg - TIMER_W'(1);
        end
    end

    // ======================================================================
    // Error density integrator
    // ======================================================================
    logic [13:0] err_win_reg;
    logic [7:0] err_cnt_reg;
    logic alarm_reg;
    logic inhibit_reg;
    logic count_en;
    logic alarm_set;
    logic sync_gain;
    assign count_en = in_sync_reg & ~inhibit_reg;
    assign alarm_set = count_en & err_pulse & (err_cnt_reg == ERR_LIMIT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_win_reg <= 14'h0;
            err_cnt_reg <= 8'h0;
        end else if (rx_strobe) begin
            err_win_reg <= err_win_reg + 14'h1;
            if (err_win_reg == ERR_WINDOW_LAST) begin
                err_cnt_reg <= 8'h0;
            end else if (count_en && err_pulse && err_cnt_reg != ERR_LIMIT) begin
                err_cnt_reg <= err_cnt_reg + 8'h1;
            end
        end
    end

    // A new alarm in the same cycle as the quiet-time clear wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_reg <= 1'b0;
            inhibit_reg <= 1'b0;
        end else begin
            if (alarm_set) begin
                alarm_reg <= 1'b1;
            end else if (quiet_expire) begin
                alarm_reg <= 1'b0;
            end
            if (alarm_set) begin
                inhibit_reg <= 1'b1;
            end else if (sync_gain) begin
                inhibit_reg <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Synchronisation state
    // ======================================================================
    logic [3:0] sync_win_reg;
    logic win_err_reg;
    assign sync_gain = rx_strobe & (sync_win_reg == SYNC_WINDOW_LAST) & ~in_sync_reg
        & ~win_err_reg & ~err_pulse;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_win_reg <= 4'h0;
            win_err_reg <= 1'b0;
        end else if (rx_strobe) begin
            sync_win_reg <= sync_win_reg + 4'h1;
            win_err_reg <= (sync_win_reg == SYNC_WINDOW_LAST) ? 1'b0 : (win_err_reg | err_pulse);
        end
    end

    // Clock loss takes priority; the alarm only occurs while in sync, so its
    // complement drops the detector back to open loop for reacquisition.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_sync_reg <= 1'b0;
        end else if (clk_missing) begin
            in_sync_reg <= 1'b0;
        end else if (alarm_set) begin
            in_sync_reg <= ~in_sync_reg;
        end else if (sync_gain) begin
            in_sync_reg <= 1'b1;
        end
    end

    // ======================================================================
    // Self-test result and indicators
    // ======================================================================
    logic st_fail_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_fail_reg <= 1'b0;
            lamps_out <= '0;
        end else begin
            st_fail_reg <= (alarm_reg & self_test) | (vfail_sync_reg[1] & voice_en);
            lamps_out.in_sync <= in_sync_reg;
            lamps_out.receive_clock_missing <= clk_missing;
            lamps_out.bit_error <= (err_timer_reg != '0);
            lamps_out.error_density_alarm <= alarm_reg;
            lamps_out.self_test_fail <= st_fail_reg;
        end
    end

    // ======================================================================
    // AHB-Lite slave, zero wait states
    // ======================================================================
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic take;
    assign take = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h0;
            ctrl_reg <= CTRL_RESET;
            hrdata <= 32'h0;
        end else begin
            wr_pend_reg <= take & hwrite;
            if (take) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (wr_pend_reg && wr_addr_reg == CTRL_OFFSET && haddr[31:8] == 24'h0) begin
                ctrl_reg <= hwdata[3:0];
            end
            if (take && !hwrite) begin
                case (haddr[7:0])
                    CTRL_OFFSET: hrdata <= {28'h0, ctrl_reg};
                    STATUS_OFFSET: hrdata <= {27'h0, st_fail_reg, alarm_reg, err_timer_reg != '0,
                        clk_missing, in_sync_reg};
                    ERRCNT_OFFSET: hrdata <= {24'h0, err_cnt_reg};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

endmodule

/* File: tb/pbt_channel_model.sv */
// Behavioural model of the data channel under test.
// Assumes the bench supplies the bit clock that also drives the tester's external clock pin.
`timescale 1ns/1ps
module pbt_channel_model (
    input wire logic bit_clock,
    input wire logic tx_pattern,
    input wire logic corrupt,
    input wire logic halt_clock,
    output logic rx_pattern,
    output logic rx_clock
);
    // A corrupted channel inverts every bit, so each received bit is an error.
    assign rx_pattern = tx_pattern ^ corrupt;
    // A halted clock stands low, as a dead receiver would leave it.
    assign rx_clock = halt_clock ? 1'b0 : bit_clock;
endmodule

/* File: tb/pbt_tester_sva.sv */
// Checker for the pattern bit error tester, watching top-level pins only.
// Assumes it is bound into pbt_tester by the bench.
`timescale 1ns/1ps
module pbt_tester_sva #(
    parameter int CLK_LOSS_CYC = 2000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic receive_clock_in,
    input wire logic voice_path_check_fail_in,
    input wire logic transmit_clock_out,
    input wire logic frame_marker_out,
    input wire pbt_pkg::pbt_lamps_t lamps_out
);
    import pbt_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ======================================================================
    // Helper
    // ======================================================================
    // Saturates so that a long quiet spell cannot wrap back below the limit.
    int quiet_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_reg <= 0;
        end else if ($rose(receive_clock_in)) begin
            quiet_reg <= 0;
        end else if (quiet_reg < CLK_LOSS_CYC + 100) begin
            quiet_reg <= quiet_reg + 1;
        end
    end
    sequence s_alarm_rise;
        $rose(lamps_out.error_density_alarm);
    endsequence
    // ======================================================================
    // Assertions
    // ======================================================================
    AST_FRAME_ON_STEP: assert property ($rose(frame_marker_out) |-> transmit_clock_out || $past(transmit_clock_out))
        else $error("frame marker rose away from a generator step");
    // A step that lands on a master edge keeps the clock high for a second master period.
    AST_TXCLK_ENDS: assert property ($rose(transmit_clock_out) |=> ##[0:105] !transmit_clock_out)
        else $error("transmit clock stuck high");
    AST_ALARM_WHILE_SYNC: assert property (s_alarm_rise |-> $past(lamps_out.in_sync) || $past(lamps_out.in_sync, 2))
        else $error("alarm raised while out of sync");
    AST_ALARM_DROPS_SYNC: assert property (s_alarm_rise |-> ##[0:2] !lamps_out.in_sync)
        else $error("alarm did not complement sync");
    AST_LOSS_DROPS_SYNC: assert property ($rose(lamps_out.receive_clock_missing) |-> ##[0:2] !lamps_out.in_sync)
        else $error("clock loss left sync set");
    AST_LOSS_TIMEOUT: assert property (quiet_reg > CLK_LOSS_CYC + 8 |-> lamps_out.receive_clock_missing)
        else $error("clock loss not flagged");
    // Only a clock returning after a real loss is watched, since at 20 kb/s the pin clock is ignored.
    AST_CLOCK_CLEARS_LOSS: assert property ($rose(receive_clock_in) && quiet_reg > CLK_LOSS_CYC |->
        ##[1:8] !lamps_out.receive_clock_missing)
        else $error("clock edge did not clear loss");
    AST_ERROR_LAMP_HOLD: assert property ($rose(lamps_out.bit_error) |=> lamps_out.bit_error [*8])
        else $error("bit error lamp not held");
    AST_FAIL_CAUSE: assert property ($rose(lamps_out.self_test_fail) |->
        lamps_out.error_density_alarm || $past(voice_path_check_fail_in, 2))
        else $error("self-test fail without cause");
endmodule

/* File: tb/pbt_tester_test.sv */
// Self-checking bench for the pattern bit error tester.
// Assumes the channel model loops the pattern back and the design is alone on the bus.
`timescale 1ns/1ps
module pbt_tester_test;
    import pbt_pkg::*;
    localparam int LOSS_CYC = 2000;
    typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic [31:0] rdata;} pbt_row_t;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic master_clock_in = 0, bit_clock = 0, rx_pattern, rx_clock, voice_fail = 0, corrupt = 0, halt = 1;
    logic tx_clk, tx_pat, frame;
    pbt_lamps_t lamps_out;
    int div_reg = 0, n_errors = 0, total_checks = 0;
    always #2.5 hclk = ~hclk;
    always #122.0703125 master_clock_in = ~master_clock_in;
    // The bit clock runs at one tenth of hclk so a frame stays short.
    always @(posedge hclk) begin
        div_reg <= (div_reg == 4) ? 0 : div_reg + 1;
        if (div_reg == 4) bit_clock <= ~bit_clock;
    end
    pbt_tester #(.CLK_LOSS_CYC(LOSS_CYC), .BIT_ERROR_CYC(5000)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .master_clock_in(master_clock_in),
        .external_clock_in(bit_clock), .receive_pattern_in(rx_pattern), .receive_clock_in(rx_clock),
        .voice_path_check_fail_in(voice_fail), .transmit_clock_out(tx_clk), .transmit_pattern_out(tx_pat),
        .frame_marker_out(frame), .lamps_out(lamps_out));
    pbt_channel_model i_chan (.bit_clock(bit_clock), .tx_pattern(tx_pat), .corrupt(corrupt), .halt_clock(halt),
        .rx_pattern(rx_pattern), .rx_clock(rx_clock));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic tx_gap(input real lo, input real hi);
        realtime t0;
        @(posedge tx_clk);
        t0 = $realtime;
        @(posedge tx_clk);
        chk({31'h0, ($realtime - t0) > lo && ($realtime - t0) < hi}, 32'h1);
        @(posedge hclk);
    endtask
    // Counts edges from one frame marker to the next and notes when the error lamp first lights.
    task automatic frame_gap(output int n, output int e);
        n = 0;
        e = 0;
        while (frame !== 1'b0 && n < 50) begin @(posedge hclk); n++; end
        while (frame !== 1'b1 && n < 30000) begin
            @(posedge hclk);
            n++;
            if (e == 0 && lamps_out.bit_error === 1'b1) e = n;
        end
    endtask
    task automatic test_done();
        $display("TB: checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #700_000;
        n_errors++;
        test_done();
    end
    initial begin
        pbt_row_t rows [5] = '{'{CTRL_OFFSET, 32'hffffffff, 32'h0000000f}, '{CTRL_OFFSET, 32'h5, 32'h5},
            '{8'h0c, 32'hffffffff, 32'h0}, '{ERRCNT_OFFSET, 32'hff, 32'h0}, '{STATUS_OFFSET, 32'hff, 32'h2}};
        logic [31:0] r;
        int n, e;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, CTRL_OFFSET, 32'h0, r);
        chk(r, 32'h0);
        chk({27'h0, lamps_out}, 32'h2);
        foreach (rows[i]) begin
            ahb(1'b1, rows[i].addr, rows[i].wdata, r);
            ahb(1'b0, rows[i].addr, 32'h0, r);
            chk(r, rows[i].rdata);
        end
        halt <= 1'b0;
        ahb(1'b1, CTRL_OFFSET, 32'h0, r);
        repeat (2) tx_gap(19750.0, 20045.0);
        ahb(1'b1, CTRL_OFFSET, 32'h1, r);
        tx_gap(50756.0, 50806.0);
        ahb(1'b1, CTRL_OFFSET, 32'h2, r);
        for (n = 0; n < 3000 && lamps_out.in_sync !== 1'b1; n++) @(posedge hclk);
        chk({31'h0, lamps_out.in_sync}, 32'h1);
        ahb(1'b0, ERRCNT_OFFSET, 32'h0, r);
        chk(r, 32'h0);
        ahb(1'b1, CTRL_OFFSET, 32'h6, r);
        frame_gap(n, e);
        frame_gap(n, e);
        chk(n, 32'd20470);
        chk({31'h0, e > 5 && e < 80}, 32'h1);
        ahb(1'b1, CTRL_OFFSET, 32'h2, r);
        corrupt <= 1'b1;
        for (n = 0; n < 4000 && lamps_out.error_density_alarm !== 1'b1; n++) @(posedge hclk);
        repeat (100) @(posedge hclk);
        chk({31'h0, lamps_out.error_density_alarm}, 32'h1);
        chk({31'h0, lamps_out.in_sync}, 32'h0);
        corrupt <= 1'b0;
        for (n = 0; n < 8000 && lamps_out.error_density_alarm !== 1'b0; n++) @(posedge hclk);
        chk({31'h0, lamps_out.error_density_alarm}, 32'h0);
        for (n = 0; n < 4000 && lamps_out.in_sync !== 1'b1; n++) @(posedge hclk);
        chk({31'h0, lamps_out.in_sync}, 32'h1);
        halt <= 1'b1;
        for (n = 0; n < LOSS_CYC + 200 && lamps_out.receive_clock_missing !== 1'b1; n++) @(posedge hclk);
        repeat (50) @(posedge hclk);
        chk({30'h0, lamps_out.receive_clock_missing, lamps_out.in_sync}, 32'h2);
        halt <= 1'b0;
        repeat (30) @(posedge hclk);
        chk({31'h0, lamps_out.receive_clock_missing}, 32'h0);
        voice_fail <= 1'b1;
        ahb(1'b1, CTRL_OFFSET, 32'ha, r);
        repeat (10) @(posedge hclk);
        chk({31'h0, lamps_out.self_test_fail}, 32'h1);
        ahb(1'b1, CTRL_OFFSET, 32'h2, r);
        repeat (10) @(posedge hclk);
        chk({31'h0, lamps_out.self_test_fail}, 32'h0);
        test_done();
    end
endmodule
bind pbt_tester pbt_tester_sva #(.CLK_LOSS_CYC(CLK_LOSS_CYC)) u_sva (.hclk(hclk), .hresetn(hresetn),
    .receive_clock_in(receive_clock_in), .voice_path_check_fail_in(voice_path_check_fail_in),
    .transmit_clock_out(transmit_clock_out), .frame_marker_out(frame_marker_out), .lamps_out(lamps_out));
